// ==== dcf_flag_fifo.sv ====
// Purpose: 18-bit FIFO with fixed, almost and half flags, offset
//   registers, fall-through option and daisy-chain depth expansion.
// Assumes: Write and read ports run on pclk; all pins except the asynchronous presetn are synchronous.
// Notes: Straps are caught while master_reset_n is low.
// Function
// R1: Master reset clears pointers, sets flags idle.
// R2: Host resets buffer before its first write.
// R3: Write enable low stores one 18-bit word.
// R4: Stored word is the present input word.
// R5: Write enable high leaves memory and pointer.
// R6: Writes while full are dropped.
// R7: Read enable low moves next word out.
// R8: Read enable high holds the output word.
// R9: Reads while empty are dropped.
// R10: Output enable low drives the output bus.
// R11: Load low writes bits 11:0 to offsets.
// R12: Load low reads offsets onto bits 11:0.
// R13: Straps select timing mode and flag style; the flag-style strap is only latched and shown in status, flags ignore it.
// R14: Chain ties first-load low only on first.
// R15: Chain links expansion inputs to previous outputs.
// R16: Full pin is full or input ready.
// R17: Empty pin is empty or output ready.
// R18: Almost-empty low within offset of empty.
// R19: Almost-full low within offset of full.
// R20: Half-full low above half occupancy.
// R21: Write expansion pulse on last location written.
// R22: Read expansion pulse on last location read.
// R23: Fall-through shows first word without a read.
// R24: Standard mode needs a read to show data.
// R25: Depth is a parameter; defaults follow it.
// R26: Offset accesses alternate empty then full offset.
// R27: Flags cross domains when clocks differ; here both ports share pclk, so there is no crossing logic.
module dcf_flag_fifo import dcf_pkg::*; #(
    parameter int DEPTH = DCF_DEPTH_DEF,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic master_reset_n,
    input wire logic write_enable_n,
    input wire logic [DCF_DATA_W-1:0] write_data,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    input wire logic offset_load_n,
    input wire logic first_in_chain_n,
    input wire logic write_expand_in_n,
    input wire logic read_expand_in_n,
    output logic full_flag_n,
    output logic empty_flag_n,
    output logic almost_empty_n,
    output logic almost_full_n,
    output logic half_full_n,
    output logic read_expand_out_n,
    output logic [DCF_DATA_W-1:0] read_data,
    output logic read_data_oe
);

    // Depth-derived constants: levels at the width of the level counter, last address at pointer width.
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_LEVEL = (AW+1)'(DEPTH / 2);
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
    // Reset default for both almost offsets. [R25]
    localparam logic [DCF_OFF_W-1:0] OFF_DEF =
        DCF_OFF_W'(dcf_default_offset(DEPTH));

    logic [AW-1:0] wptr; // Next location to write.
    logic [AW-1:0] rptr; // Next location to read.
    logic [AW:0] count; // Words held in the array.
    logic [AW:0] next_count; // Level after this edge.
    logic [DCF_OFF_W-1:0] ae_off; // Almost-empty offset.
    logic [DCF_OFF_W-1:0] af_off; // Almost-full offset.
    dcf_off_sel_t off_sel; // Offset register for the next load access.
    logic fall_through; // Fall-through timing selected.
    logic async_flags; // Asynchronous almost-flag style selected.
    logic chain_en; // Depth expansion enabled by software.
    logic wtok; // This device owns the write side of the chain.
    logic rtok; // This device owns the read side of the chain.
    logic out_valid; // Fall-through word sits on the outputs.
    logic next_out_valid; // Output valid after this edge.
    logic fetch_pend; // A RAM read lands in the output next edge.
    logic [DCF_DATA_W-1:0] ram_q; // Registered RAM read data.
    logic wr_mem; // Store a word this edge.
    logic rd_mem; // Pop a word from the RAM this edge.
    logic wr_off; // Offset register write this edge.
    logic rd_off; // Offset register readback this edge.
    logic consume; // Fall-through reader takes the shown word.
    logic wxo_pulse; // Last location written in chain mode.
    logic rxo_pulse; // Last location read in chain mode.
    logic is_full; // Array holds DEPTH words.
    logic is_empty; // Array holds no words.

    assign is_full = (count == FULL_LEVEL);
    assign is_empty = (count == '0);

    // Request decode. A full or empty array, or a missing chain token,
    // silently drops the request; the pins already warned the party.
    always_comb begin
        wr_off = !write_enable_n && !offset_load_n; // [R11]
        rd_off = !read_enable_n && !offset_load_n; // [R12]
        wr_mem = !write_enable_n && offset_load_n && !is_full // [R3] [R6]
            && (!chain_en || wtok); // [R15]
        consume = fall_through && out_valid && !read_enable_n
            && offset_load_n;
        if (fall_through) begin
            // Auto fetch keeps the output stage filled. [R23]
            rd_mem = !is_empty && !fetch_pend && offset_load_n
                && (!out_valid || consume);
        end else begin
            // Only an explicit read shows data. [R7] [R9] [R24]
            rd_mem = !read_enable_n && offset_load_n && !is_empty
                && (!chain_en || rtok);
        end
        wxo_pulse = chain_en && wr_mem && (wptr == LAST_ADDR);
        rxo_pulse = chain_en && rd_mem && (rptr == LAST_ADDR);
        next_count = count + {{AW{1'b0}}, wr_mem} - {{AW{1'b0}}, rd_mem};
        if (fetch_pend) begin
            next_out_valid = 1'b1;
        end else if (consume) begin
            next_out_valid = 1'b0;
        end else begin
            next_out_valid = out_valid;
        end
    end

    // Word store; the write takes the present input word. [R4]
    dcf_ram #(
        .W(DCF_DATA_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_ram (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_mem),
        .wr_addr(wptr),
        .wr_data(write_data),
        .rd_en(rd_mem),
        .rd_addr(rptr),
        .rd_data(ram_q)
    );

    // Pointers, level and output-stage state. Master reset brings
    // both pointers back to location zero. [R1]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            fetch_pend <= 1'b0;
        end else if (!master_reset_n) begin
            wptr <= '0; // [R1]
            rptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            fetch_pend <= 1'b0;
        end else begin
            if (wr_mem) begin
                wptr <= wptr + 1'b1; // [R3] [R5]
            end
            if (rd_mem) begin
                rptr <= rptr + 1'b1; // [R7]
            end
            count <= next_count;
            out_valid <= next_out_valid;
            fetch_pend <= rd_mem;
        end
    end

    // Output word register. It only changes when a RAM read lands or
    // an offset is read back, so it holds otherwise. [R8]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data <= '0;
        end else if (rd_off) begin
            // Offset readback wins; upper bits read as zero. [R12]
            if (off_sel == DCF_SEL_EMPTY) begin
                read_data <= {{(DCF_DATA_W-DCF_OFF_W){1'b0}}, ae_off};
            end else begin
                read_data <= {{(DCF_DATA_W-DCF_OFF_W){1'b0}}, af_off};
            end
        end else if (fetch_pend) begin
            read_data <= ram_q; // [R7]
        end
    end

    // Output enable, registered so the pin comes from a flop; the bus
    // follows output_enable_n one cycle late. [R10]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data_oe <= 1'b0;
        end else begin
            read_data_oe <= !output_enable_n; // [R10]
        end
    end

    // Offset registers and their shared step-through selector. A write
    // and a readback in the same edge step the selector only once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ae_off <= OFF_DEF;
            af_off <= OFF_DEF;
            off_sel <= DCF_SEL_EMPTY;
        end else if (!master_reset_n) begin
            ae_off <= OFF_DEF; // [R18] [R19] [R25]
            af_off <= OFF_DEF;
            off_sel <= DCF_SEL_EMPTY;
        end else begin
            if (wr_off && off_sel == DCF_SEL_EMPTY) begin
                ae_off <= write_data[DCF_OFF_W-1:0]; // [R11]
            end
            if (wr_off && off_sel == DCF_SEL_FULL) begin
                af_off <= write_data[DCF_OFF_W-1:0]; // [R11]
            end
            if (wr_off || rd_off) begin
                // Empty offset first, then full, then wrap. [R26]
                if (off_sel == DCF_SEL_EMPTY) begin
                    off_sel <= DCF_SEL_FULL;
                end else begin
                    off_sel <= DCF_SEL_EMPTY;
                end
            end
        end
    end

    // Mode straps are caught while master reset is held. Chain mode
    // forces standard timing since the chain passes tokens, not data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_through <= 1'b0;
            async_flags <= 1'b0;
        end else if (!master_reset_n) begin
            fall_through <= !chain_en && !read_expand_in_n; // [R13]
            async_flags <= !chain_en && !write_expand_in_n; // [R13]
        end
    end

    // Chain tokens. The first device starts owning both sides; a token
    // moves on when this device uses its last location. [R14] [R15]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wtok <= 1'b0;
            rtok <= 1'b0;
        end else if (!master_reset_n) begin
            wtok <= !first_in_chain_n; // [R14]
            rtok <= !first_in_chain_n;
        end else begin
            // An arriving token wins over our own hand-off.
            if (chain_en && !write_expand_in_n) begin
                wtok <= 1'b1; // [R15]
            end else if (wxo_pulse) begin
                wtok <= 1'b0;
            end
            if (chain_en && !read_expand_in_n) begin
                rtok <= 1'b1; // [R15]
            end else if (rxo_pulse) begin
                rtok <= 1'b0;
            end
        end
    end

    // Flag pins, all registered from the level, output stage or expansion pulses after this edge. With a
    // single clock every flag lives in one domain, so no synchroniser
    // is needed and the flags carry no extra crossing latency. [R27]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_flag_n <= 1'b1;
            almost_full_n <= 1'b1;
            empty_flag_n <= 1'b0;
            almost_empty_n <= 1'b0;
            half_full_n <= 1'b1;
            read_expand_out_n <= 1'b1;
        end else if (!master_reset_n) begin
            full_flag_n <= 1'b1; // [R1]
            almost_full_n <= 1'b1;
            empty_flag_n <= 1'b0;
            almost_empty_n <= 1'b0;
            half_full_n <= 1'b1;
            read_expand_out_n <= 1'b1;
        end else begin
            if (fall_through) begin
                // Low means room for another write. [R16]
                full_flag_n <= (next_count == FULL_LEVEL);
                // Low means a valid word is on the outputs. [R17]
                empty_flag_n <= !next_out_valid;
            end else begin
                full_flag_n <= (next_count != FULL_LEVEL); // [R16]
                empty_flag_n <= (next_count != '0); // [R17]
            end
            // Within the programmed distance of empty. [R18]
            almost_empty_n <= ({{(DCF_OFF_W+1-AW){1'b0}}, next_count}
                > {2'b00, ae_off});
            // Within the programmed distance of full. [R19]
            almost_full_n <= ({{(DCF_OFF_W+1-AW){1'b0}}, next_count}
                + {2'b00, af_off}) < {{(DCF_OFF_W+1-AW){1'b0}}, FULL_LEVEL};
            if (chain_en) begin
                half_full_n <= !wxo_pulse; // [R21]
            end else begin
                half_full_n <= !(next_count > HALF_LEVEL); // [R20]
            end
            read_expand_out_n <= !rxo_pulse; // [R22]
        end
    end

    // APB control register: only the chain enable is writable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_en <= DCF_CTRL_CHAIN_RESET;
        end else if (psel && penable && pwrite
            && paddr == DCF_CTRL_ADDR) begin
            chain_en <= pwdata[DCF_CTRL_CHAIN_BIT];
        end
    end

    // APB read data and error, prepared in the setup cycle so that the
    // zero-wait access phase presents them from flops. Unmapped reads
    // and writes to read-only words answer with an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b1;
        end else if (psel && !penable) begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b1;
            if (paddr == DCF_CTRL_ADDR) begin
                prdata[DCF_CTRL_CHAIN_BIT] <= chain_en;
            end else if (paddr == DCF_STATUS_ADDR) begin
                prdata[DCF_ST_FULL_BIT] <= is_full;
                prdata[DCF_ST_EMPTY_BIT] <= is_empty;
                prdata[DCF_ST_AE_BIT] <= !almost_empty_n;
                prdata[DCF_ST_AF_BIT] <= !almost_full_n;
                prdata[DCF_ST_HF_BIT] <= (count > HALF_LEVEL);
                prdata[DCF_ST_FALL_THROUGH_MODE_BIT] <= fall_through;
                prdata[DCF_ST_ASYNC_BIT] <= async_flags;
                prdata[DCF_ST_WTOK_BIT] <= wtok;
                prdata[DCF_ST_RTOK_BIT] <= rtok;
                pslverr <= pwrite;
            end else if (paddr == DCF_LEVEL_ADDR) begin
                prdata[AW:0] <= count;
                pslverr <= pwrite;
            end else if (paddr == DCF_OFFSET_ADDR) begin
                prdata[DCF_OFF_W-1:0] <= ae_off;
                prdata[DCF_OFFSET_AF_LSB +: DCF_OFF_W] <= af_off;
                pslverr <= pwrite;
            end else begin
                pslverr <= 1'b1;
            end
        end
    end

    // Checks on the block's own outputs and state.
    default clocking dcf_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_flags: assert property ( // [R1]
        !master_reset_n |=> full_flag_n && almost_full_n && !empty_flag_n
            && !almost_empty_n && count == '0 && wptr == '0)
        else $error("Master reset left flags or pointers wrong.");

    a_write_counts: assert property ( // [R3]
        master_reset_n && wr_mem && !rd_mem
            |=> count == $past(count) + 1'b1)
        else $error("Accepted write did not raise the level.");

    a_write_idle: assert property ( // [R5]
        master_reset_n && write_enable_n |=> wptr == $past(wptr))
        else $error("Write pointer moved without a write.");

    a_full_refused: assert property ( // [R6]
        master_reset_n && is_full && !write_enable_n
            |=> wptr == $past(wptr))
        else $error("Write accepted while full.");

    a_read_hold: assert property ( // [R8]
        read_enable_n && !fetch_pend |=> $stable(read_data))
        else $error("Output word changed without a read.");

    a_empty_refused: assert property ( // [R9]
        master_reset_n && is_empty |=> rptr == $past(rptr))
        else $error("Read pointer moved while empty.");

    a_oe_follow: assert property ( // [R10]
        output_enable_n |=> !read_data_oe)
        else $error("Bus driven while output enable high.");

    a_offset_write: assert property ( // [R11]
        master_reset_n && wr_off && off_sel == DCF_SEL_EMPTY
            |=> ae_off == $past(write_data[DCF_OFF_W-1:0])
                && off_sel == DCF_SEL_FULL)
        else $error("Almost-empty offset load failed.");

    a_std_empty: assert property ( // [R17]
        !fall_through |-> empty_flag_n == (count != '0))
        else $error("Empty pin disagrees with level.");

    a_half_full: assert property ( // [R20]
        !chain_en && $past(!chain_en) && $past(master_reset_n)
            |-> half_full_n == !(count > HALF_LEVEL))
        else $error("Half-full pin disagrees with level.");

    a_fall_through_mode_show: assert property ( // [R23]
        master_reset_n && fall_through && is_empty && !out_valid
            && !fetch_pend && wr_mem && !rd_off
            ##1 master_reset_n[*2] |-> ##1 !empty_flag_n)
        else $error("First word did not fall through.");

endmodule // dcf_flag_fifo

// ==== dcf_flag_fifo_bench.sv ====
// Purpose: Self-checking bench for the flag FIFO and its APB window.
// Assumes: Depth 256; single-device mode; first_in_chain_n held high, expansion straps low only for the fall-through test.
// Notes: Every task that drives a pin starts at a clock edge, so no signal is set twice.
module dcf_flag_fifo_bench import dcf_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // One APB row: request beside the answer it should give.
    typedef struct {
        logic [11:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } dcf_row_t;
    localparam int DEPTH = DCF_DEPTH_DEF;
    localparam logic [31:0] OFF_DEF = 32'(DCF_OFF_DEF_256);
    logic pclk = 1'b0, presetn = 1'b0, master_reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e;
    logic wr_go = 1'b0, rd_go = 1'b0, output_enable_n = 1'b1;
    logic offset_load_n = 1'b1, read_expand_in_n = 1'b1;
    logic write_expand_in_n = 1'b1;
    logic [17:0] wr_word = 18'h0, write_data, read_data;
    logic write_enable_n, read_enable_n, read_data_oe, read_expand_out_n;
    logic full_flag_n, empty_flag_n, almost_empty_n, almost_full_n;
    logic half_full_n;
    int n_errors = 0, tests_run = 0;
    dcf_row_t rows [7] = '{
        '{DCF_CTRL_ADDR, 1'b0, 32'h0, 32'h0, 1'b0},
        '{DCF_CTRL_ADDR, 1'b1, 32'h0, 32'h0, 1'b0},
        '{DCF_STATUS_ADDR, 1'b0, 32'h0, (32'h1 << DCF_ST_EMPTY_BIT) |
            (32'h1 << DCF_ST_AE_BIT), 1'b0},
        '{DCF_LEVEL_ADDR, 1'b0, 32'h0, 32'h0, 1'b0},
        '{DCF_OFFSET_ADDR, 1'b0, 32'h0,
            (OFF_DEF << DCF_OFFSET_AF_LSB) | OFF_DEF, 1'b0},
        '{DCF_STATUS_ADDR, 1'b1, 32'hff, 32'h0, 1'b1},
        '{12'h010, 1'b0, 32'h0, 32'h0, 1'b1}};

    always #12.5 pclk = ~pclk;

    dcf_flag_fifo dcf_flag_fifo_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_reset_n(master_reset_n),
        .write_enable_n(write_enable_n), .write_data(write_data),
        .read_enable_n(read_enable_n), .output_enable_n(output_enable_n),
        .offset_load_n(offset_load_n), .first_in_chain_n(1'b1),
        .write_expand_in_n(write_expand_in_n),
        .read_expand_in_n(read_expand_in_n),
        .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
        .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
        .half_full_n(half_full_n), .read_expand_out_n(read_expand_out_n),
        .read_data(read_data), .read_data_oe(read_data_oe));
    dcf_stream_partner dcf_stream_partner_i (.pclk(pclk), .wr_go(wr_go),
        .wr_word(wr_word), .rd_go(rd_go), .write_enable_n(write_enable_n),
        .write_data(write_data), .read_enable_n(read_enable_n));

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; only the watchdog bounds the wait for pready.
    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Back-to-back writes of n words counting up from b.
    task automatic push(input int n, input logic [17:0] b);
        @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            wr_go <= 1'b1;
            wr_word <= b + 18'(i);
            @(posedge pclk);
        end
        wr_go <= 1'b0;
    endtask

    // One read; the word lands one edge after the taking edge.
    task automatic pop(input logic [17:0] x);
        @(posedge pclk);
        rd_go <= 1'b1;
        @(posedge pclk);
        rd_go <= 1'b0;
        @(posedge pclk);
        #1;
        chk(32'(read_data), 32'(x));
    endtask

    // Applies master reset with the straps already set.
    task automatic fifo_reset();
        @(posedge pclk);
        master_reset_n <= 1'b0;
        repeat (2) @(posedge pclk);
        master_reset_n <= 1'b1;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs under 2000 cycles.
    initial begin
        repeat (8000) @(posedge pclk);
        n_errors++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        master_reset_n <= 1'b1;
        @(posedge pclk);
        #1;
        chk(32'({full_flag_n, almost_full_n, empty_flag_n, almost_empty_n,
            half_full_n, read_expand_out_n}), 32'h33);
        $display("reset test done");
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            chk(32'(e), 32'(rows[i].e));
            if (!rows[i].w) begin
                chk(q, rows[i].q);
            end
        end
        $display("register rows done");
        push(DEPTH + 1, 18'h15000);
        @(posedge pclk);
        #1;
        chk(32'({full_flag_n, almost_full_n, half_full_n}),
            32'h0);
        apb(DCF_LEVEL_ADDR, 1'b0, 32'h0);
        chk(q, 32'(DEPTH));
        for (int i = 0; i < DEPTH; i++) begin
            pop(18'h15000 + 18'(i));
        end
        repeat (3) @(posedge pclk);
        chk(32'(read_data), 32'h150ff);
        pop(18'h150ff);
        chk(32'({empty_flag_n, almost_empty_n}), 32'h0);
        apb(DCF_LEVEL_ADDR, 1'b0, 32'h0);
        chk(q, 32'h0);
        $display("fill and drain done");
        output_enable_n <= 1'b0;
        @(posedge pclk);
        #1;
        chk(32'(read_data_oe), 32'h1);
        @(posedge pclk);
        output_enable_n <= 1'b1;
        offset_load_n <= 1'b0;
        push(2, 18'h3f004);
        apb(DCF_OFFSET_ADDR, 1'b0, 32'h0);
        chk(q, 32'h00050004);
        pop(18'h00004);
        @(posedge pclk);
        offset_load_n <= 1'b1;
        $display("offset test done");
        read_expand_in_n <= 1'b0;
        write_expand_in_n <= 1'b0;
        fifo_reset();
        push(1, 18'h2b00d);
        repeat (2) @(posedge pclk);
        #1;
        chk(32'(read_data), 32'h2b00d);
        chk(32'({empty_flag_n, full_flag_n}), 32'h0);
        apb(DCF_STATUS_ADDR, 1'b0, 32'h0);
        chk(q, 32'h66);
        $display("fall-through test done");
        summarize();
    end
endmodule // dcf_flag_fifo_bench

// ==== dcf_pkg.sv ====
// Purpose: Shared constants for the flag FIFO block and its memory.
// Assumes: One clock domain; APB register window with 32-bit data.
// Notes: Every offset, bit position and reset value is named here once.
package dcf_pkg;

    // Word width of the data ports and width of the offset registers.
    localparam int DCF_DATA_W = 18;
    localparam int DCF_OFF_W = 12;
    // Default storage depth in words.
    localparam int DCF_DEPTH_DEF = 256;

    // Default almost offsets for the three depth classes.
    localparam int DCF_OFF_DEF_256 = 31;
    localparam int DCF_OFF_DEF_512 = 63;
    localparam int DCF_OFF_DEF_BIG = 127;

    // APB register byte addresses.
    localparam logic [11:0] DCF_CTRL_ADDR = 12'h000;
    localparam logic [11:0] DCF_STATUS_ADDR = 12'h004;
    localparam logic [11:0] DCF_LEVEL_ADDR = 12'h008;
    localparam logic [11:0] DCF_OFFSET_ADDR = 12'h00c;

    // Control register layout and reset value.
    localparam int DCF_CTRL_CHAIN_BIT = 0;
    localparam logic DCF_CTRL_CHAIN_RESET = 1'h0;

    // Status register bit positions.
    localparam int DCF_ST_FULL_BIT = 0;
    localparam int DCF_ST_EMPTY_BIT = 1;
    localparam int DCF_ST_AE_BIT = 2;
    localparam int DCF_ST_AF_BIT = 3;
    localparam int DCF_ST_HF_BIT = 4;
    localparam int DCF_ST_FALL_THROUGH_MODE_BIT = 5;
    localparam int DCF_ST_ASYNC_BIT = 6;
    localparam int DCF_ST_WTOK_BIT = 7;
    localparam int DCF_ST_RTOK_BIT = 8;

    // Offset readback: almost-full offset sits at this bit.
    localparam int DCF_OFFSET_AF_LSB = 16;

    // Which offset register the next load access touches.
    typedef enum logic {DCF_SEL_EMPTY, DCF_SEL_FULL} dcf_off_sel_t;

    // Default almost offset for a given depth.
    function automatic int dcf_default_offset(input int depth);
        if (depth == 256) begin
            return DCF_OFF_DEF_256;
        end else if (depth == 512) begin
            return DCF_OFF_DEF_512;
        end
        return DCF_OFF_DEF_BIG;
    endfunction

endpackage

// ==== dcf_ram.sv ====
// Purpose: Simple dual-port word store for the flag FIFO.
// Assumes: One clock; read data is registered and held when idle.
// Notes: The array itself has no reset, only its read register does.
module dcf_ram #(
    parameter int W = 18,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);

    // Storage array, left without reset to stay a plain RAM.
    logic [W-1:0] mem [DEPTH];

    // Write port.
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port; holds its value when no read is issued.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // dcf_ram

// ==== dcf_stream_partner.sv ====
// Purpose: Upstream writer and downstream reader beside the FIFO pins.
// Assumes: The bench raises the request levels just after a pclk edge.
// Notes: An idle writer shows the inverse of its last word on the bus.
module dcf_stream_partner import dcf_pkg::*; (
    input wire logic pclk,
    input wire logic wr_go,
    input wire logic [DCF_DATA_W-1:0] wr_word,
    input wire logic rd_go,
    output logic write_enable_n,
    output logic [DCF_DATA_W-1:0] write_data,
    output logic read_enable_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // Last word offered, kept so an idle bus never repeats it.
    logic [DCF_DATA_W-1:0] last_word = '0;

    // Strobes are the request levels, active low.
    assign write_enable_n = !wr_go;
    assign read_enable_n = !rd_go;
    // Idle data is scrambled so a stray write would show a wrong word.
    assign write_data = wr_go ? wr_word : ~last_word;

    // Remember each word as it is offered.
    always_ff @(posedge pclk) begin
        if (wr_go) begin
            last_word <= wr_word;
        end
    end
endmodule // dcf_stream_partner
